// >>> rtl/dra_regs.vh
// Register offsets, fields, reset values and limits of the display RAM address and write block
`ifndef DRA_REGS_VH
`define DRA_REGS_VH

// Byte offsets on the register bus
`define DRA_OFF_ACCESS_CTRL  8'h00
`define DRA_OFF_COLUMN       8'h04
`define DRA_OFF_ROW          8'h08
`define DRA_OFF_WIN_MIN_COL  8'h0C
`define DRA_OFF_WIN_MAX_COL  8'h10
`define DRA_OFF_WIN_MIN_ROW  8'h14
`define DRA_OFF_WIN_MAX_ROW  8'h18
`define DRA_OFF_PORT_MODE    8'h1C
`define DRA_OFF_PIXEL        8'h20
`define DRA_OFF_STATUS       8'h24

// Data access control field positions
`define DRA_BIT_ROW_FIRST    0
`define DRA_BIT_WINDOW       1
`define DRA_BIT_COL_MIRROR   2
`define DRA_BIT_ROW_MIRROR   3
`define DRA_BIT_BURST        6

// Port mode fields and codes
`define DRA_BIT_PIX16        4
`define DRA_MODE_PAR18       3'h0
`define DRA_MODE_PAR16       3'h1
`define DRA_MODE_PAR8        3'h2
`define DRA_MODE_SERIAL      3'h3
`define DRA_MODE_RGB         3'h4

// Geometry
`define DRA_COL_FIRST        8'h00
`define DRA_COL_LAST         8'hEF
`define DRA_ROW_FIRST        9'h000
`define DRA_ROW_LAST         9'h13F
`define DRA_DEPTH            76800

// Reset values
`define DRA_RST_ACCESS_CTRL  8'h00
`define DRA_RST_PORT_MODE    3'h0

`endif

// >>> rtl/dra_frame_mem.v
// Frame memory: two write ports, host and display read ports with registered data
`timescale 1ns/1ps
module dra_frame_mem #(
    parameter DW    = 18,
    parameter AW    = 17,
    parameter DEPTH = 76800
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rstn,
    // First write port
    input  wire          we_a,
    input  wire [AW-1:0] addr_a,
    input  wire [DW-1:0] wd_a,
    // Second write port, used for the second pixel of a pair
    input  wire          we_b,
    input  wire [AW-1:0] addr_b,
    input  wire [DW-1:0] wd_b,
    // Host read port
    input  wire          re_h,
    input  wire [AW-1:0] addr_h,
    output reg  [DW-1:0] rd_h,
    // Display scan read port
    input  wire          re_d,
    input  wire [AW-1:0] addr_d,
    output reg  [DW-1:0] rd_d
);

    reg [DW-1:0] mem [0:DEPTH-1];

    // Pair addresses coincide only in a one-pixel window, where the second write port wins
    always @(posedge clk) begin
        if (we_a)
            mem[addr_a] <= wd_a;
        if (we_b)
            mem[addr_b] <= wd_b;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_h <= {DW{1'b0}};
            rd_d <= {DW{1'b0}};
        end else begin
            if (re_h)
                rd_h <= mem[addr_h];
            if (re_d)
                rd_d <= mem[addr_d];
        end
    end

endmodule // dra_frame_mem

// >>> rtl/dra_pair_hold.v
// Holding register that gathers two pixels before they are committed together
`timescale 1ns/1ps
module dra_pair_hold #(
    parameter DW = 18
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rstn,
    // Pixel input
    input  wire          push,
    input  wire          discard,
    input  wire [DW-1:0] pix,
    // Pair output
    output wire          pair_done,
    output reg  [DW-1:0] held,
    output reg           slot
);

    // Discard drops a stale half pair so the new pixel starts a fresh one
    assign pair_done = push & slot & ~discard;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held <= {DW{1'b0}};
            slot <= 1'b0;
        end else if (push) begin
            if (discard || !slot) begin
                held <= pix;
                slot <= 1'b1;
            end else begin
                slot <= 1'b0;
            end
        end
    end

endmodule // dra_pair_hold

// >>> rtl/dra_top.v
// Display RAM address generator and write path behind an AHB-Lite register slave
`timescale 1ns/1ps
`include "dra_regs.vh"

module dra_top #(
    parameter PIX_W  = 18,
    parameter ADDR_W = 17,
    parameter DEPTH  = `DRA_DEPTH
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rstn,
    // AHB-Lite slave
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire              hreadyout,
    output wire              hresp,
    output reg  [31:0]       hrdata,
    // RGB pass-through pixel stream
    input  wire              rgb_through,
    input  wire              rgb_valid,
    input  wire [PIX_W-1:0]  rgb_pixel,
    output wire              rgb_accept,
    // Display scan port
    input  wire              disp_req,
    input  wire [7:0]        disp_source,
    input  wire [8:0]        disp_gate,
    output wire [PIX_W-1:0]  disp_pixel,
    output reg               disp_valid
);

    // Linear memory address of a pixel: row * 240 + column
    function [16:0] lin_addr;
        input [8:0] r;
        input [7:0] c;
        begin
            lin_addr = {r, 8'h00} - {4'h0, r, 4'h0} + {9'h000, c};
        end
    endfunction

    // Next address after one access, within the given bounds
    function [16:0] step_addr;
        input [7:0] c;
        input [8:0] r;
        input       row_first;
        input [7:0] cmin;
        input [7:0] cmax;
        input [8:0] rmin;
        input [8:0] rmax;
        begin
            if (!row_first) begin
                if (c == cmax) begin
                    step_addr[7:0]  = cmin;
                    step_addr[16:8] = (r == rmax) ? rmin : r + 9'h001;
                end else begin
                    step_addr[7:0]  = c + 8'h01;
                    step_addr[16:8] = r;
                end
            end else begin
                if (r == rmax) begin
                    step_addr[16:8] = rmin;
                    step_addr[7:0]  = (c == cmax) ? cmin : c + 8'h01;
                end else begin
                    step_addr[16:8] = r + 9'h001;
                    step_addr[7:0]  = c;
                end
            end
        end
    endfunction

    // 16-bit RGB565 pixel widened to 18 bits by repeating the top bit of red and of blue
    function [17:0] widen16;
        input [15:0] p;
        begin
            widen16 = {p[15:11], p[15], p[10:5], p[4:0], p[4]};
        end
    endfunction

    // Control state
    reg              row_first;
    reg              win_en;
    reg              col_mirror;
    reg              row_mirror;
    reg              burst_bit;
    reg [2:0]        port_mode;
    reg              pix16;
    reg [7:0]        cur_col;
    reg [8:0]        cur_row;
    reg [7:0]        win_min_col;
    reg [7:0]        win_max_col;
    reg [8:0]        win_min_row;
    reg [8:0]        win_max_row;
    reg              reg_access_seen;
    reg [PIX_W-1:0]  rd_latch;
    reg              rd_pending;
    reg              ap_valid;
    reg              ap_write;
    reg [7:0]        ap_addr;

    wire [PIX_W-1:0] mem_rd_h;
    wire [PIX_W-1:0] held_pix;
    wire             hold_slot;
    wire             pair_done;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase take and data phase write
    wire ap_take   = hsel & hready & htrans[1];
    wire dp_write  = ap_valid & ap_write;
    wire dp_pixel  = dp_write & (ap_addr == `DRA_OFF_PIXEL);
    wire pix_read  = ap_take & ~hwrite & (haddr[7:0] == `DRA_OFF_PIXEL);
    wire reg_touch = ap_take & (haddr[7:0] != `DRA_OFF_PIXEL);

    // Effective bounds: full frame unless the window is on
    wire [7:0] cmin = win_en ? win_min_col : `DRA_COL_FIRST;
    wire [7:0] cmax = win_en ? win_max_col : `DRA_COL_LAST;
    wire [8:0] rmin = win_en ? win_min_row : `DRA_ROW_FIRST;
    wire [8:0] rmax = win_en ? win_max_row : `DRA_ROW_LAST;

    // Direction applies inside the window as well
    wire [16:0] step1 = step_addr(cur_col, cur_row, row_first, cmin, cmax, rmin, rmax);
    wire [16:0] step2 = step_addr(step1[7:0], step1[16:8], row_first, cmin, cmax, rmin, rmax);

    // Pair writing only on the wide parallel ports
    wire burst_on = burst_bit & ((port_mode == `DRA_MODE_PAR18) | (port_mode == `DRA_MODE_PAR16));

    wire [PIX_W-1:0] pix_in = pix16 ? widen16(hwdata[15:0]) : hwdata[17:0];

    wire single_wr = dp_pixel & ~burst_on;
    wire burst_push = dp_pixel & burst_on;

    // Host pixel traffic has priority; the stream waits during host pixel writes and reads and while the window is on
    assign rgb_accept = rgb_through & ~win_en & ~dp_pixel & ~pix_read;
    wire rgb_wr = rgb_valid & rgb_accept;

    dra_pair_hold #(
        .DW        (PIX_W)
    ) u_hold (
        .clk       (clk),
        .rstn      (rstn),
        .push      (burst_push),
        .discard   (reg_access_seen),
        .pix       (pix_in),
        .pair_done (pair_done),
        .held      (held_pix),
        .slot      (hold_slot)
    );

    // First pixel of a pair at the current address, second one step on
    wire             we_a   = single_wr | pair_done | rgb_wr;
    wire [PIX_W-1:0] wd_a   = pair_done ? held_pix : (single_wr ? pix_in : rgb_pixel);
    wire [16:0]      addr_a = lin_addr(cur_row, cur_col);
    wire [16:0]      addr_b = lin_addr(step1[16:8], step1[7:0]);

    // Display scan: mirrors choose which column and row feed each output
    wire [7:0]  scan_col  = col_mirror ? `DRA_COL_LAST - disp_source : disp_source;
    wire [8:0]  scan_row  = row_mirror ? `DRA_ROW_LAST - disp_gate : disp_gate;
    wire [16:0] scan_addr = lin_addr(scan_row, scan_col);

    dra_frame_mem #(
        .DW     (PIX_W),
        .AW     (ADDR_W),
        .DEPTH  (DEPTH)
    ) u_mem (
        .clk    (clk),
        .rstn   (rstn),
        .we_a   (we_a),
        .addr_a (addr_a),
        .wd_a   (wd_a),
        .we_b   (pair_done),
        .addr_b (addr_b),
        .wd_b   (pix_in),
        .re_h   (pix_read),
        .addr_h (addr_a),
        .rd_h   (mem_rd_h),
        .re_d   (disp_req),
        .addr_d (scan_addr),
        .rd_d   (disp_pixel)
    );

    // Register read mux, sampled in the address phase
    reg [31:0] read_mux;
    always @* begin
        read_mux = 32'h0000_0000;
        case (haddr[7:0])
            `DRA_OFF_ACCESS_CTRL: begin
                read_mux[`DRA_BIT_ROW_FIRST]  = row_first;
                read_mux[`DRA_BIT_WINDOW]     = win_en;
                read_mux[`DRA_BIT_COL_MIRROR] = col_mirror;
                read_mux[`DRA_BIT_ROW_MIRROR] = row_mirror;
                read_mux[`DRA_BIT_BURST]      = burst_bit;
            end
            `DRA_OFF_COLUMN:      read_mux[7:0] = cur_col;
            `DRA_OFF_ROW:         read_mux[8:0] = cur_row;
            `DRA_OFF_WIN_MIN_COL: read_mux[7:0] = win_min_col;
            `DRA_OFF_WIN_MAX_COL: read_mux[7:0] = win_max_col;
            `DRA_OFF_WIN_MIN_ROW: read_mux[8:0] = win_min_row;
            `DRA_OFF_WIN_MAX_ROW: read_mux[8:0] = win_max_row;
            `DRA_OFF_PORT_MODE: begin
                read_mux[2:0]            = port_mode;
                read_mux[`DRA_BIT_PIX16] = pix16;
            end
            // First read after an address load returns stale data
            `DRA_OFF_PIXEL:       read_mux[17:0] = rd_pending ? mem_rd_h : rd_latch;
            `DRA_OFF_STATUS: begin
                read_mux[7:0]   = cur_col;
                read_mux[16:8]  = cur_row;
                read_mux[24]    = hold_slot;
                read_mux[25]    = burst_on;
            end
            default:              read_mux = 32'h0000_0000;
        endcase
    end

    // Bus phase tracking and read data
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ap_valid   <= 1'b0;
            ap_write   <= 1'b0;
            ap_addr    <= 8'h00;
            hrdata     <= 32'h0000_0000;
            rd_latch   <= {PIX_W{1'b0}};
            rd_pending <= 1'b0;
            disp_valid <= 1'b0;
        end else begin
            if (hready) begin
                ap_valid <= ap_take;
                ap_write <= hwrite;
                ap_addr  <= haddr[7:0];
            end
            if (ap_take && !hwrite)
                hrdata <= read_mux;
            rd_pending <= pix_read;
            if (rd_pending)
                rd_latch <= mem_rd_h;
            disp_valid <= disp_req;
        end
    end

    // Any access to a register other than the pixel one marks the held half pair as stale; set wins over clear
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            reg_access_seen <= 1'b0;
        else
            reg_access_seen <= reg_touch | (reg_access_seen & ~dp_pixel);
    end

    // Configuration registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            row_first   <= 1'b0;
            win_en      <= 1'b0;
            col_mirror  <= 1'b0;
            row_mirror  <= 1'b0;
            burst_bit   <= 1'b0;
            port_mode   <= `DRA_RST_PORT_MODE;
            pix16       <= 1'b0;
            win_min_col <= `DRA_COL_FIRST;
            win_max_col <= `DRA_COL_LAST;
            win_min_row <= `DRA_ROW_FIRST;
            win_max_row <= `DRA_ROW_LAST;
        end else if (dp_write) begin
            case (ap_addr)
                `DRA_OFF_ACCESS_CTRL: begin
                    row_first  <= hwdata[`DRA_BIT_ROW_FIRST];
                    win_en     <= hwdata[`DRA_BIT_WINDOW];
                    col_mirror <= hwdata[`DRA_BIT_COL_MIRROR];
                    row_mirror <= hwdata[`DRA_BIT_ROW_MIRROR];
                    burst_bit  <= hwdata[`DRA_BIT_BURST];
                end
                `DRA_OFF_WIN_MIN_COL: win_min_col <= hwdata[7:0];
                `DRA_OFF_WIN_MAX_COL: win_max_col <= hwdata[7:0];
                `DRA_OFF_WIN_MIN_ROW: win_min_row <= hwdata[8:0];
                `DRA_OFF_WIN_MAX_ROW: win_max_row <= hwdata[8:0];
                `DRA_OFF_PORT_MODE: begin
                    port_mode <= hwdata[2:0];
                    pix16     <= hwdata[`DRA_BIT_PIX16];
                end
                default: begin
                end
            endcase
        end
    end

    // Address counters: loads, then host writes, then host reads, then the stream
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_col <= `DRA_COL_FIRST;
            cur_row <= `DRA_ROW_FIRST;
        end else if (dp_write && ap_addr == `DRA_OFF_COLUMN) begin
            cur_col <= hwdata[7:0];
        end else if (dp_write && ap_addr == `DRA_OFF_ROW) begin
            cur_row <= hwdata[8:0];
        end else if (pair_done) begin
            cur_col <= step2[7:0];
            cur_row <= step2[16:8];
        end else if (single_wr || pix_read || rgb_wr) begin
            // A half pair leaves the counters alone until its partner arrives
            cur_col <= step1[7:0];
            cur_row <= step1[16:8];
        end
    end

endmodule // dra_top

// >>> verification/dra_top_checker.sv
// Port-level assertions for the display RAM address and write block
`timescale 1ns/1ps
module dra_top_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Stream and display
    input wire logic        rgb_through,
    input wire logic        rgb_accept,
    input wire logic        disp_req,
    input wire logic        disp_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_read;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_col_read;
        s_read ##0 (haddr[7:0] == 8'h04);
    endsequence
    sequence s_row_read;
        s_read ##0 (haddr[7:0] == 8'h08);
    endsequence

    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not OKAY");
    chk_hrdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed without a read");
    chk_unmapped_zero: assert property (s_read ##0 (haddr[7:0] >= 8'h28) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_col_range: assert property (s_col_read |=> hrdata <= 32'hEF)
        else $error("column beyond last");
    chk_row_range: assert property (s_row_read |=> hrdata <= 32'h13F)
        else $error("row beyond last");
    chk_disp_answer: assert property (disp_req |=> disp_valid)
        else $error("display read not answered");
    chk_disp_cause: assert property (disp_valid |-> $past(disp_req))
        else $error("display valid without request");
    chk_rgb_gate: assert property (rgb_accept |-> rgb_through)
        else $error("stream accepted outside pass-through");
endmodule // dra_top_checker

bind dra_top dra_top_checker i_chk (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .rgb_through, .rgb_accept, .disp_req, .disp_valid);

// >>> verification/dra_rgb_src.sv
// Pass-through pixel stream source that stands in for the far side
`timescale 1ns/1ps
module dra_rgb_src #(
    parameter PIX_W = 18
) (
    // Clock
    input  wire logic             clk,
    // Stream
    input  wire logic             rgb_accept,
    output logic                  rgb_valid,
    output logic [PIX_W-1:0]      rgb_pixel
);
    initial begin
        rgb_valid = 1'b0;
        rgb_pixel = '0;
    end

    // Held until taken or 50 cycles pass; released data is inverted so stale values never look valid
    task automatic send(input logic [PIX_W-1:0] p, output logic ok);
        int n;
        ok = 1'b0;
        rgb_valid <= 1'b1;
        rgb_pixel <= p;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk);
            ok = (rgb_accept === 1'b1);
        end
        rgb_valid <= 1'b0;
        rgb_pixel <= ~p;
    endtask
endmodule // dra_rgb_src

// >>> verification/tb_top.sv
// Self-checking bench for the display RAM address and write block
`timescale 1ns/1ps
module tb_top;
    logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, rgb_through = 0, disp_req = 0, ok;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  disp_source = 8'h00;
    logic [8:0]  disp_gate = 9'h000;
    wire         hready, hreadyout, hresp, rgb_valid, rgb_accept, disp_valid;
    wire  [31:0] hrdata;
    wire  [17:0] rgb_pixel, disp_pixel;
    int          errors = 0, total_checks = 0;

    always #5 clk = ~clk;
    assign hready = hreadyout;

    dra_top i_dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .rgb_through, .rgb_valid, .rgb_pixel, .rgb_accept, .disp_req, .disp_source,
        .disp_gate, .disp_pixel, .disp_valid);
    dra_rgb_src i_src (.clk, .rgb_accept, .rgb_valid, .rgb_pixel);

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(what, q, exp);
    endtask
    task xy(input logic [31:0] c, input logic [31:0] r);
        wr(8'h04, c);
        wr(8'h08, r);
    endtask
    // First read after a load only primes the fetch
    task pc(input logic [31:0] c, input logic [31:0] r, input logic [31:0] exp);
        xy(c, r);
        bus(8'h20, 1'b0, 32'h0);
        rc("pixel", 8'h20, exp);
    endtask
    task disp(input logic [7:0] s, input logic [8:0] g, input logic [31:0] exp);
        disp_req <= 1'b1;
        disp_source <= s;
        disp_gate <= g;
        @(posedge clk);
        disp_req <= 1'b0;
        // Valid pulses for one cycle only, so look just after the answering edge
        #1;
        chk("disp_valid", {31'h0, disp_valid}, 32'h1);
        chk("disp_pixel", {14'h0, disp_pixel}, exp);
        @(posedge clk);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop;
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rc("ctrl", 8'h00, 32'h0);
        rc("column", 8'h04, 32'h0);
        rc("row", 8'h08, 32'h0);
        rc("win max col", 8'h10, 32'hEF);
        rc("win max row", 8'h18, 32'h13F);
        rc("unmapped", 8'h30, 32'h0);
        xy(32'hEE, 32'h5);
        wr(8'h20, 32'h1);
        wr(8'h20, 32'h2);
        rc("column", 8'h04, 32'h0);
        rc("row", 8'h08, 32'h6);
        xy(32'hEF, 32'h13F);
        wr(8'h20, 32'h3);
        rc("column", 8'h04, 32'h0);
        rc("row", 8'h08, 32'h0);
        wr(8'h00, 32'h1);
        xy(32'h3, 32'h13E);
        wr(8'h20, 32'h4);
        wr(8'h20, 32'h5);
        rc("column", 8'h04, 32'h4);
        rc("row", 8'h08, 32'h0);
        // Window 10..12 by 20..21, start on the last column
        wr(8'h0C, 32'h10);
        wr(8'h10, 32'h12);
        wr(8'h14, 32'h20);
        wr(8'h18, 32'h21);
        wr(8'h00, 32'h2);
        xy(32'h12, 32'h20);
        wr(8'h20, 32'h6);
        rc("column", 8'h04, 32'h10);
        rc("row", 8'h08, 32'h21);
        wr(8'h20, 32'h7);
        wr(8'h20, 32'h8);
        wr(8'h20, 32'h9);
        rc("column", 8'h04, 32'h10);
        rc("row", 8'h08, 32'h20);
        rgb_through <= 1'b1;
        @(posedge clk);
        chk("rgb_accept", {31'h0, rgb_accept}, 32'h0);
        wr(8'h00, 32'h0);
        xy(32'h20, 32'h30);
        i_src.send(18'h2AB, ok);
        chk("stream taken", {31'h0, ok}, 32'h1);
        rgb_through <= 1'b0;
        pc(32'h20, 32'h30, 32'h2AB);
        pc(32'hEE, 32'h5, 32'h1);
        pc(32'hEF, 32'h5, 32'h2);
        // Burst: pair, lone half dropped by a register access, then a fresh pair
        wr(8'h00, 32'h40);
        xy(32'h4, 32'h7);
        wr(8'h20, 32'h11);
        wr(8'h20, 32'h12);
        rc("column", 8'h04, 32'h6);
        wr(8'h20, 32'h13);
        rc("column", 8'h04, 32'h6);
        wr(8'h20, 32'h14);
        wr(8'h20, 32'h15);
        rc("column", 8'h04, 32'h8);
        wr(8'h00, 32'h41);
        xy(32'h8, 32'h7);
        wr(8'h20, 32'h16);
        wr(8'h20, 32'h17);
        wr(8'h00, 32'h0);
        pc(32'h8, 32'h7, 32'h16);
        pc(32'h8, 32'h8, 32'h17);
        pc(32'h4, 32'h7, 32'h11);
        pc(32'h6, 32'h7, 32'h14);
        pc(32'h7, 32'h7, 32'h15);
        // Narrow port ignores the burst bit
        wr(8'h1C, 32'h2);
        wr(8'h00, 32'h40);
        xy(32'h0, 32'h0);
        wr(8'h20, 32'h18);
        rc("column", 8'h04, 32'h1);
        wr(8'h1C, 32'h0);
        xy(32'h0, 32'h0);
        wr(8'h20, 32'h21);
        wr(8'h20, 32'h22);
        wr(8'h20, 32'h23);
        wr(8'h20, 32'h24);
        rc("column", 8'h04, 32'h4);
        wr(8'h00, 32'h0);
        disp(8'h00, 9'h000, 32'h21);
        wr(8'h00, 32'h4);
        disp(8'hEF, 9'h000, 32'h21);
        wr(8'h00, 32'h8);
        disp(8'h00, 9'h13F, 32'h21);
        // 16-bit port with 16-bit pixels: a lone half shows in status, then a plain write widens
        wr(8'h1C, 32'h11);
        wr(8'h00, 32'h40);
        xy(32'h2, 32'h1);
        wr(8'h20, 32'hF800);
        rc("status", 8'h24, 32'h0300_0102);
        wr(8'h00, 32'h0);
        wr(8'h20, 32'hF800);
        wr(8'h1C, 32'h0);
        pc(32'h2, 32'h1, 32'h3F000);
        report_and_stop;
    end
endmodule // tb_top
